//--- src/htx_pkg.sv
package htx_pkg;

  // Frame type codes carried in the first byte of each transmitted frame.
  localparam logic [7:0] FIS_TYPE_REG_H2D = 8'h27;
  localparam logic [7:0] FIS_TYPE_DMA_SETUP = 8'h41;
  localparam logic [7:0] FIS_TYPE_SELFTEST = 8'h58;

  // Index of the final dword of each frame kind.
  localparam logic [2:0] LAST_IDX_REG = 3'h4;
  localparam logic [2:0] LAST_IDX_DMA = 3'h6;
  localparam logic [2:0] LAST_IDX_SELFTEST = 3'h2;

  // Flag byte fields of the register and DMA setup frames.
  localparam int CMD_FLAG_BIT = 7;
  localparam int DMA_DIR_BIT = 5;
  localparam int DMA_IRQ_BIT = 6;

  // Soft reset bit of the device control register and its reset value.
  localparam int SRST_BIT = 2;
  localparam logic [7:0] DEVCTL_RESET = 8'h00;
  localparam logic [7:0] COMMAND_RESET = 8'h00;

  // Opcode of the DEVICE RESET command.
  localparam logic [7:0] DEVICE_RESET_OPCODE = 8'h08;

  // Slots of the pending request flags.
  localparam int PEND_CMD = 0;
  localparam int PEND_CTL = 1;
  localparam int PEND_DMA = 2;
  localparam int PEND_SELFTEST = 3;
  localparam int PEND_COUNT = 4;

  // Which transmit sequence is in progress.
  typedef enum logic [1:0] {
    kind_command,
    kind_control,
    kind_dma_setup,
    kind_selftest
  } htx_kind_t;

  // Transmit sequencer states.
  typedef enum logic [2:0] {
    host_idle_state,
    command_frame_build_state,
    control_frame_build_state,
    dma_setup_frame_build_state,
    selftest_frame_build_state,
    ending_status_wait_state
  } htx_state_t;

endpackage

//--- src/htx_pend.sv
`timescale 1ns/1ps
`default_nettype none

// One sticky request flag; a set in the same cycle as a clear wins.
module htx_pend
(
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_set,
  input  wire logic i_clear,
  output logic      o_flag
);

  logic next_flag;

  // The set term is outside the clear mask so a request that lands on the clear is kept.
  always_comb
  begin
    next_flag = i_set | (o_flag & ~i_clear);
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      o_flag <= 1'b0;
    else
      o_flag <= next_flag;
  end

endmodule

`default_nettype wire

//--- src/htx_frame_dword.sv
`timescale 1ns/1ps
`default_nettype none

// Produces one dword of the frame of the given kind at the given index.
module htx_frame_dword
(
  input  wire htx_pkg::htx_kind_t i_kind,
  input  wire logic [2:0]         i_index,
  input  wire logic [7:0]         i_command,
  input  wire logic [7:0]         i_devctl,
  input  wire logic [7:0]         i_features,
  input  wire logic [7:0]         i_features_exp,
  input  wire logic [23:0]        i_lba,
  input  wire logic [23:0]        i_lba_exp,
  input  wire logic [7:0]         i_device,
  input  wire logic [15:0]        i_count,
  input  wire logic               i_dma_dir,
  input  wire logic               i_dma_irq,
  input  wire logic [63:0]        i_dma_buf_id,
  input  wire logic [31:0]        i_dma_offset,
  input  wire logic [31:0]        i_dma_count,
  input  wire logic [7:0]         i_st_pattern,
  input  wire logic [63:0]        i_st_data,
  output logic [31:0]             o_dword
);
  import htx_pkg::*;

  logic [7:0] flags;

  // Register frames differ only in the command flag; unused slots read zero.
  always_comb
  begin
    flags = 8'h00;
    o_dword = 32'h0;
    unique case (i_kind)
      kind_command, kind_control:
      begin
        flags[CMD_FLAG_BIT] = (i_kind == kind_command);
        unique case (i_index)
          3'h0: o_dword = {i_features, i_command, flags, FIS_TYPE_REG_H2D};
          3'h1: o_dword = {i_device, i_lba};
          3'h2: o_dword = {i_features_exp, i_lba_exp};
          3'h3: o_dword = {i_devctl, 8'h00, i_count};
          default: o_dword = 32'h0;
        endcase
      end
      kind_dma_setup:
      begin
        flags[DMA_DIR_BIT] = i_dma_dir;
        flags[DMA_IRQ_BIT] = i_dma_irq;
        unique case (i_index)
          3'h0: o_dword = {16'h0, flags, FIS_TYPE_DMA_SETUP};
          3'h1: o_dword = i_dma_buf_id[31:0];
          3'h2: o_dword = i_dma_buf_id[63:32];
          3'h4: o_dword = i_dma_offset;
          3'h5: o_dword = i_dma_count;
          default: o_dword = 32'h0;
        endcase
      end
      kind_selftest:
      begin
        unique case (i_index)
          3'h0: o_dword = {8'h00, i_st_pattern, 8'h00, FIS_TYPE_SELFTEST};
          3'h1: o_dword = i_st_data[31:0];
          3'h2: o_dword = i_st_data[63:32];
          default: o_dword = 32'h0;
        endcase
      end
    endcase
  end

endmodule

`default_nettype wire

//--- src/htx_transmit.sv
// Behaviour
// - Shadow command write builds a register frame, flags it pending, hands it over.
// - After the last dword, pulse frame end and enter the ending status wait.
// - Illegal transition from the link in any build or wait state returns to idle.
// - Incoming frame during any build abandons transmission and returns to idle.
// - The wait state holds until link and phy report final status.
// - Error-free status in the wait state returns every sequence to idle.
// - Command error without soft reset rebuilds and resends the command frame.
// - Command error with soft reset or packet DEVICE RESET sends SYNC and idles.
// - Device control write builds a register frame and passes it to the link.
// - Control frame error rebuilds and resends the control frame.
// - Application request builds a DMA setup frame with direction, buffer, offset, count, irq.
// - The DMA setup frame is followed by data frames, sent by other logic.
// - DMA setup error without soft reset reports status and rebuilds the frame.
// - Soft reset or DEVICE RESET during DMA setup wait sends SYNC and idles.
// - Self-test frame is sent, then idle; the application then enters test mode.
// - Self-test frame error returns to the build state and resends.
// - A control sequence starts only when a write changes the soft reset bit.
`timescale 1ns/1ps
`default_nettype none

module htx_transmit
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  // Shadow register writes and contents.
  input  wire logic               i_cmd_wr,
  input  wire logic [7:0]         i_cmd_wdata,
  input  wire logic               i_devctl_wr,
  input  wire logic [7:0]         i_devctl_wdata,
  input  wire logic [7:0]         i_sh_features,
  input  wire logic [7:0]         i_sh_features_exp,
  input  wire logic [23:0]        i_sh_lba,
  input  wire logic [23:0]        i_sh_lba_exp,
  input  wire logic [7:0]         i_sh_device,
  input  wire logic [15:0]        i_sh_count,
  input  wire logic               i_packet_device,
  // Application requests.
  input  wire logic               i_dma_req,
  input  wire logic               i_dma_dir,
  input  wire logic               i_dma_irq,
  input  wire logic [63:0]        i_dma_buf_id,
  input  wire logic [31:0]        i_dma_offset,
  input  wire logic [31:0]        i_dma_count,
  input  wire logic               i_st_req,
  input  wire logic [7:0]         i_st_pattern,
  input  wire logic [63:0]        i_st_data,
  // Link layer side.
  input  wire logic               i_link_dword_ready,
  input  wire logic               i_link_rx_start,
  input  wire logic               i_link_illegal,
  input  wire logic               i_link_status_valid,
  input  wire logic               i_link_status_err,
  output logic                    o_link_frame_pending,
  output logic [31:0]             o_link_dword,
  output logic                    o_link_dword_valid,
  output logic                    o_link_frame_end,
  output logic                    o_link_send_sync,
  output logic                    o_link_status_report,
  // Status toward software and application.
  output logic                    o_idle,
  output logic                    o_soft_reset,
  output logic                    o_done,
  output htx_pkg::htx_kind_t      o_done_kind
);
  import htx_pkg::*;

  htx_state_t          state;
  htx_state_t          next_state;
  htx_kind_t           kind;
  htx_kind_t           next_kind;
  logic [2:0]          idx;
  logic [2:0]          next_idx;
  logic                load;
  logic [31:0]         bld_dword;
  logic [31:0]         next_dword;
  logic                next_valid;
  logic                next_pending;
  logic                next_end;
  logic                next_sync;
  logic                next_report;
  logic                next_done;
  logic [PEND_COUNT-1:0] pend;
  logic [PEND_COUNT-1:0] pend_set;
  logic [PEND_COUNT-1:0] pend_clr;
  logic [7:0]          command;
  logic [7:0]          next_command;
  logic [7:0]          devctl;
  logic [7:0]          next_devctl;
  logic                devrst;
  logic                next_devrst;
  logic                dma_dir;
  logic                dma_irq;
  logic [63:0]         dma_buf_id;
  logic [31:0]         dma_offset;
  logic [31:0]         dma_count;
  logic [7:0]          st_pattern;
  logic [63:0]         st_data;
  logic                srst;

  assign srst = devctl[SRST_BIT];

  // Build state that belongs to each sequence kind.
  function automatic htx_state_t build_state(input htx_kind_t k);
    htx_state_t s;
    unique case (k)
      kind_command:   s = command_frame_build_state;
      kind_control:   s = control_frame_build_state;
      kind_dma_setup: s = dma_setup_frame_build_state;
      kind_selftest:  s = selftest_frame_build_state;
    endcase
    return s;
  endfunction

  // Final dword index of each frame kind.
  function automatic logic [2:0] last_idx(input htx_kind_t k);
    logic [2:0] n;
    unique case (k)
      kind_command, kind_control: n = LAST_IDX_REG;
      kind_dma_setup:             n = LAST_IDX_DMA;
      kind_selftest:              n = LAST_IDX_SELFTEST;
    endcase
    return n;
  endfunction

  // Requests raised while a sequence runs wait in sticky flags.
  assign pend_set[PEND_CMD] = i_cmd_wr;
  assign pend_set[PEND_CTL] = i_devctl_wr && (i_devctl_wdata[SRST_BIT] != srst);
  assign pend_set[PEND_DMA] = i_dma_req;
  assign pend_set[PEND_SELFTEST] = i_st_req;

  genvar g;
  generate
    for (g = 0; g < PEND_COUNT; g++)
    begin : g_pend
      htx_pend u_pend
      (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_set     (pend_set[g]),
        .i_clear   (pend_clr[g]),
        .o_flag    (pend[g])
      );
    end
  endgenerate

  // Dword of the frame at the index that will be presented next.
  htx_frame_dword u_frame
  (
    .i_kind         (next_kind),
    .i_index        (next_idx),
    .i_command      (command),
    .i_devctl       (devctl),
    .i_features     (i_sh_features),
    .i_features_exp (i_sh_features_exp),
    .i_lba          (i_sh_lba),
    .i_lba_exp      (i_sh_lba_exp),
    .i_device       (i_sh_device),
    .i_count        (i_sh_count),
    .i_dma_dir      (dma_dir),
    .i_dma_irq      (dma_irq),
    .i_dma_buf_id   (dma_buf_id),
    .i_dma_offset   (dma_offset),
    .i_dma_count    (dma_count),
    .i_st_pattern   (st_pattern),
    .i_st_data      (st_data),
    .o_dword        (bld_dword)
  );

  // The dword only changes when loaded, so it stays stable while the link stalls.
  assign next_dword = load ? bld_dword : o_link_dword;

  // Sequencer: start from idle, hand over dwords, judge the ending status.
  always_comb
  begin
    next_state = state;
    next_kind = kind;
    next_idx = idx;
    load = 1'b0;
    next_valid = o_link_dword_valid;
    next_pending = o_link_frame_pending;
    next_end = 1'b0;
    next_sync = 1'b0;
    next_report = 1'b0;
    next_done = 1'b0;
    pend_clr = '0;
    next_devrst = devrst;
    unique case (state)
      host_idle_state:
      begin
        // A frame arriving from the device owns the link; starts wait for it.
        if (!i_link_rx_start)
        begin
          load = |pend;
          if (pend[PEND_CMD])
          begin
            next_kind = kind_command;
            pend_clr[PEND_CMD] = 1'b1;
          end
          else if (pend[PEND_CTL])
          begin
            next_kind = kind_control;
            pend_clr[PEND_CTL] = 1'b1;
          end
          else if (pend[PEND_DMA])
          begin
            next_kind = kind_dma_setup;
            pend_clr[PEND_DMA] = 1'b1;
          end
          else if (pend[PEND_SELFTEST])
          begin
            next_kind = kind_selftest;
            pend_clr[PEND_SELFTEST] = 1'b1;
          end
          if (|pend)
          begin
            next_state = build_state(next_kind);
            next_idx = 3'h0;
            next_valid = 1'b1;
            next_pending = 1'b1;
          end
        end
      end
      command_frame_build_state, control_frame_build_state,
      dma_setup_frame_build_state, selftest_frame_build_state:
      begin
        if (i_link_illegal || i_link_rx_start)
        begin
          next_state = host_idle_state;
          next_valid = 1'b0;
          next_pending = 1'b0;
        end
        else if (o_link_dword_valid && i_link_dword_ready)
        begin
          if (idx == last_idx(kind))
          begin
            next_state = ending_status_wait_state;
            next_valid = 1'b0;
            next_pending = 1'b0;
            next_end = 1'b1;
          end
          else
          begin
            next_idx = idx + 3'h1;
            load = 1'b1;
          end
        end
      end
      ending_status_wait_state:
      begin
        if (i_link_illegal)
          next_state = host_idle_state;
        else if (kind == kind_dma_setup && (srst || devrst))
        begin
          next_state = host_idle_state;
          next_sync = 1'b1;
          next_devrst = 1'b0;
        end
        else if (i_link_status_valid)
        begin
          if (!i_link_status_err)
          begin
            next_state = host_idle_state;
            next_done = 1'b1;
          end
          else if (kind == kind_command && (srst || (devrst && i_packet_device)))
          begin
            next_state = host_idle_state;
            next_sync = 1'b1;
            next_devrst = 1'b0;
          end
          else
          begin
            // Every other error resends the same frame, with no retry cap.
            next_state = build_state(kind);
            next_idx = 3'h0;
            load = 1'b1;
            next_valid = 1'b1;
            next_pending = 1'b1;
            next_report = (kind == kind_dma_setup);
          end
        end
      end
    endcase
    // A new command write decides the reset flag and beats any clear above.
    if (i_cmd_wr)
      next_devrst = (i_cmd_wdata == DEVICE_RESET_OPCODE);
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= host_idle_state;
      kind <= kind_command;
      idx <= 3'h0;
      devrst <= 1'b0;
      o_link_dword <= 32'h0;
      o_link_dword_valid <= 1'b0;
      o_link_frame_pending <= 1'b0;
      o_link_frame_end <= 1'b0;
      o_link_send_sync <= 1'b0;
      o_link_status_report <= 1'b0;
      o_idle <= 1'b1;
      o_done <= 1'b0;
      o_done_kind <= kind_command;
    end
    else
    begin
      state <= next_state;
      kind <= next_kind;
      idx <= next_idx;
      devrst <= next_devrst;
      o_link_dword <= next_dword;
      o_link_dword_valid <= next_valid;
      o_link_frame_pending <= next_pending;
      o_link_frame_end <= next_end;
      o_link_send_sync <= next_sync;
      o_link_status_report <= next_report;
      o_idle <= (next_state == host_idle_state);
      o_done <= next_done;
      o_done_kind <= kind;
    end
  end

  // Shadow command and device control copies that feed the register frames.
  always_comb
  begin
    next_command = i_cmd_wr ? i_cmd_wdata : command;
    next_devctl = i_devctl_wr ? i_devctl_wdata : devctl;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      command <= COMMAND_RESET;
      devctl <= DEVCTL_RESET;
      o_soft_reset <= 1'b0;
    end
    else
    begin
      command <= next_command;
      devctl <= next_devctl;
      o_soft_reset <= next_devctl[SRST_BIT];
    end
  end

  // Fields latch on the request so a retry resends them; a new request replaces them.
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dma_dir <= 1'b0;
      dma_irq <= 1'b0;
      dma_buf_id <= 64'h0;
      dma_offset <= 32'h0;
      dma_count <= 32'h0;
      st_pattern <= 8'h00;
      st_data <= 64'h0;
    end
    else
    begin
      if (i_dma_req)
      begin
        dma_dir <= i_dma_dir;
        dma_irq <= i_dma_irq;
        dma_buf_id <= i_dma_buf_id;
        dma_offset <= i_dma_offset;
        dma_count <= i_dma_count;
      end
      if (i_st_req)
      begin
        st_pattern <= i_st_pattern;
        st_data <= i_st_data;
      end
    end
  end

endmodule

`default_nettype wire

//--- verification/htx_link_model.sv
`timescale 1ns/1ps
`default_nettype none

module htx_link_model
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_frame_end,
  input  wire logic       i_mute,
  input  wire logic       i_rearm,
  input  wire logic [1:0] i_errs,
  output logic            o_status_valid,
  output logic            o_status_err
);
  logic [2:0] pipe;
  logic [1:0] n_stat;
  logic       toggle;

  // Status trails the frame end by three cycles, so the wait is really held.
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pipe   <= 3'h0;
      n_stat <= 2'h0;
      toggle <= 1'b0;
    end
    else
    begin
      pipe   <= {pipe[1:0], i_frame_end};
      toggle <= !toggle;
      if (i_rearm)
        n_stat <= 2'h0;
      else if (o_status_valid && n_stat != 2'h3)
        n_stat <= n_stat + 2'h1;
    end
  end

  // One status per frame, the first i_errs in error; the flag wanders outside it.
  assign o_status_valid = pipe[2] && !i_mute;
  assign o_status_err   = o_status_valid ? (n_stat < i_errs) : toggle;
endmodule

`default_nettype wire

//--- verification/htx_transmit_checker.sv
`timescale 1ns/1ps
`default_nettype none

module htx_transmit_checker
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_link_dword_ready,
  input  wire logic        i_link_rx_start,
  input  wire logic        i_link_illegal,
  input  wire logic        i_link_status_valid,
  input  wire logic        i_link_status_err,
  input  wire logic        o_link_frame_pending,
  input  wire logic [31:0] o_link_dword,
  input  wire logic        o_link_dword_valid,
  input  wire logic        o_link_frame_end,
  input  wire logic        o_link_send_sync,
  input  wire logic        o_link_status_report,
  input  wire logic        o_idle,
  input  wire logic        o_done
);
  // Busy but presenting nothing means the ending status is awaited.
  wire logic in_wait = !o_idle && !o_link_dword_valid;
  wire logic stat_ok = in_wait && i_link_status_valid && !i_link_illegal;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  property p_hold;
    o_link_dword_valid && !i_link_dword_ready && !i_link_illegal && !i_link_rx_start
      |=> o_link_dword_valid && $stable(o_link_dword);
  endproperty
  a_hold: assert property (p_hold) else $error("dword moved while stalled");
  property p_end;
    o_link_frame_end |-> $past(o_link_dword_valid && i_link_dword_ready) && in_wait
      && !o_link_frame_pending;
  endproperty
  a_end: assert property (p_end) else $error("frame end out of place");
  property p_illegal;
    !o_idle && i_link_illegal |=> o_idle && !o_link_frame_end && !o_done;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal did not idle");
  property p_rx;
    o_link_dword_valid && i_link_rx_start |=> o_idle && !o_link_dword_valid && !o_link_frame_end;
  endproperty
  a_rx: assert property (p_rx) else $error("incoming frame did not abort");
  property p_wait;
    in_wait && !i_link_status_valid && !i_link_illegal |=> !o_idle || o_link_send_sync;
  endproperty
  a_wait: assert property (p_wait) else $error("left wait without status");
  property p_ok;
    stat_ok && !i_link_status_err |=> o_idle && (o_done || o_link_send_sync);
  endproperty
  a_ok: assert property (p_ok) else $error("good status did not idle");
  property p_err;
    stat_ok && i_link_status_err |=> (o_link_dword_valid && !o_done) || (o_idle && o_link_send_sync);
  endproperty
  a_err: assert property (p_err) else $error("bad status not handled");
  property p_report;
    o_link_status_report |-> o_link_dword_valid && !o_idle && $past(in_wait);
  endproperty
  a_report: assert property (p_report) else $error("status report out of place");
  property p_sync;
    o_link_send_sync |-> o_idle && !o_link_dword_valid && !o_link_frame_pending && $past(in_wait);
  endproperty
  a_sync: assert property (p_sync) else $error("sync out of place");
  property p_done;
    o_done |-> (o_idle && $past(in_wait)) ##1 !o_done;
  endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
endmodule

bind htx_transmit htx_transmit_checker u_htx_transmit_checker
(
  .i_ref_clk, .i_rst, .i_link_dword_ready, .i_link_rx_start, .i_link_illegal,
  .i_link_status_valid, .i_link_status_err, .o_link_frame_pending, .o_link_dword,
  .o_link_dword_valid, .o_link_frame_end, .o_link_send_sync, .o_link_status_report,
  .o_idle, .o_done
);

`default_nettype wire

//--- verification/htx_transmit_tb.sv
`timescale 1ns/1ps
`default_nettype none

module htx_transmit_tb;
  import htx_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [5:0]  strb = 6'h00;
  logic        stall = 1'b0;
  logic        mute = 1'b0;
  logic        rearm = 1'b0;
  logic        pkt = 1'b0, dir = 1'b0, irq = 1'b1;
  logic [31:0] offs = 32'h00001000, cnt = 32'h00002000;
  logic [1:0]  errs = 2'h0;
  logic [7:0]  cmd_val = 8'h00;
  logic [7:0]  ctl_val = 8'h00;
  logic [7:0]  sh_feat = 8'h11, pat = 8'hA5;
  logic [63:0] buf_id = 64'h0123456789ABCDEF;
  logic [63:0] st_data = 64'hFEDCBA9876543210;
  logic [31:0] got[0:15];
  logic [31:0] o_link_dword;
  logic [1:0]  kind;
  logic        o_link_dword_valid, o_link_frame_end, o_link_send_sync, o_link_status_report;
  logic        o_idle, o_soft_reset, o_done, stat_v, stat_e;
  htx_kind_t   o_done_kind;
  int          n_fail = 0, n_compared = 0, n_got, n_end, n_sync, n_rep, n_done, cycles = 0;

  htx_transmit u_htx_transmit
  (
    .i_ref_clk, .i_rst, .i_cmd_wr(strb[0]), .i_cmd_wdata(cmd_val),
    .i_devctl_wr(strb[1]), .i_devctl_wdata(ctl_val), .i_sh_features(sh_feat),
    .i_sh_features_exp(8'h22), .i_sh_lba(24'h334455), .i_sh_lba_exp(24'h667788),
    .i_sh_device(8'hE0), .i_sh_count(16'h9A0B), .i_packet_device(pkt),
    .i_dma_req(strb[2]), .i_dma_dir(dir), .i_dma_irq(irq), .i_dma_buf_id(buf_id),
    .i_dma_offset(offs), .i_dma_count(cnt), .i_st_req(strb[3]),
    .i_st_pattern(pat), .i_st_data(st_data), .i_link_dword_ready(!stall),
    .i_link_rx_start(strb[5]), .i_link_illegal(strb[4]), .i_link_status_valid(stat_v),
    .i_link_status_err(stat_e), .o_link_frame_pending(), .o_link_dword,
    .o_link_dword_valid, .o_link_frame_end, .o_link_send_sync, .o_link_status_report,
    .o_idle, .o_soft_reset, .o_done, .o_done_kind
  );

  htx_link_model u_htx_link_model
  (
    .i_ref_clk, .i_rst, .i_frame_end(o_link_frame_end), .i_mute(mute),
    .i_rearm(rearm), .i_errs(errs), .o_status_valid(stat_v), .o_status_err(stat_e)
  );

  initial
  begin
    forever #5 i_ref_clk = !i_ref_clk;
  end

  // Records accepted dwords and output pulses; also cuts a hang short.
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (o_link_dword_valid && !stall)
    begin
      got[n_got[3:0]] = o_link_dword;
      n_got++;
    end
    n_end += int'(o_link_frame_end);
    n_sync += int'(o_link_send_sync);
    n_rep += int'(o_link_status_report);
    if (o_done)
    begin
      n_done++;
      kind = o_done_kind;
    end
    if (cycles == 5000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    n_compared++;
    if (act !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic hit(input int b);
    @(posedge i_ref_clk);
    strb[b] <= 1'b1;
    @(posedge i_ref_clk);
    strb[b] <= 1'b0;
  endtask

  // Clears the tallies and sets how many statuses report an error.
  task automatic clr(input logic [1:0] e);
    @(posedge i_ref_clk);
    {n_got, n_end, n_sync, n_rep, n_done} = '0;
    errs <= e;
    rearm <= 1'b1;
    @(posedge i_ref_clk);
    rearm <= 1'b0;
  endtask

  // Bounded waits for a completion or sync, a frame end, a presented dword.
  task automatic wait_ev(input int want);
    for (int k = 0; k < 300 && n_done + n_sync < want; k++)
      @(posedge i_ref_clk);
  endtask

  task automatic wait_end();
    for (int k = 0; k < 100 && n_end == 0; k++)
      @(posedge i_ref_clk);
  endtask

  task automatic wait_valid();
    for (int k = 0; k < 50 && o_link_dword_valid !== 1'b1; k++)
      @(posedge i_ref_clk);
  endtask

  task automatic chk_reg(input int b, input logic [7:0] c, fl, dc);
    chk(got[b], {sh_feat, c, fl, FIS_TYPE_REG_H2D});
    chk(got[b + 1], {8'hE0, 24'h334455});
    chk(got[b + 2], {8'h22, 24'h667788});
    chk(got[b + 3], {dc, 8'h00, 16'h9A0B});
    chk(got[b + 4], 32'h0);
  endtask

  task automatic t_cmd();
    clr(2'h1);
    cmd_val <= 8'hEC;
    hit(0);
    #1 chk(o_link_dword_valid, 32'h0);
    @(posedge i_ref_clk);
    #1 chk(o_link_dword_valid, 32'h1);
    wait_ev(1);
    chk(n_got, 32'd10);
    chk(n_end, 32'd2);
    chk_reg(0, 8'hEC, 8'h80, 8'h00);
    chk_reg(5, 8'hEC, 8'h80, 8'h00);
    chk(kind, kind_command);
  endtask

  task automatic t_ctl();
    clr(2'h1);
    ctl_val <= 8'h04;
    hit(1);
    wait_ev(1);
    chk(n_got, 32'd10);
    chk_reg(0, 8'hEC, 8'h00, 8'h04);
    chk_reg(5, 8'hEC, 8'h00, 8'h04);
    chk(o_soft_reset, 32'h1);
    chk(kind, kind_control);
    clr(2'h0);
    hit(1);
    repeat (10) @(posedge i_ref_clk);
    chk(n_got, 32'd0);
  endtask

  task automatic t_srst();
    clr(2'h1);
    cmd_val <= 8'hC8;
    hit(0);
    wait_ev(1);
    chk(n_sync, 32'd1);
    chk(n_got, 32'd5);
    chk(n_done, 32'd0);
    chk_reg(0, 8'hC8, 8'h80, 8'h04);
    clr(2'h0);
    ctl_val <= 8'h00;
    hit(1);
    wait_ev(1);
    chk(o_soft_reset, 32'h0);
    chk(kind, kind_control);
    clr(2'h1);
    {pkt, cmd_val} <= {1'b1, DEVICE_RESET_OPCODE};
    hit(0);
    wait_ev(1);
    chk(n_sync, 32'd1);
  endtask

  task automatic t_dma();
    clr(2'h1);
    hit(2);
    wait_ev(1);
    chk(n_rep, 32'd1);
    chk(n_got, 32'd14);
    for (int b = 0; b < 14; b += 7)
    begin
      chk(got[b], {16'h0000, (8'(dir) << DMA_DIR_BIT) | (8'(irq) << DMA_IRQ_BIT),
                   FIS_TYPE_DMA_SETUP});
      chk(got[b + 1], buf_id[31:0]);
      chk(got[b + 2], buf_id[63:32]);
      chk(got[b + 3], 32'h0);
      chk(got[b + 4], offs);
      chk(got[b + 5], cnt);
      chk(got[b + 6], 32'h0);
    end
    chk(kind, kind_dma_setup);
  endtask

  task automatic t_dma_srst();
    clr(2'h0);
    mute <= 1'b1;
    hit(2);
    wait_end();
    repeat (4) @(posedge i_ref_clk);
    ctl_val <= 8'h04;
    hit(1);
    wait_ev(1);
    mute <= 1'b0;
    chk(n_sync, 32'd1);
    chk(n_done, 32'd0);
    wait_ev(2);
    chk(kind, kind_control);
  endtask

  task automatic t_st();
    clr(2'h1);
    hit(3);
    wait_ev(1);
    chk(n_got, 32'd6);
    chk(got[0], {8'h00, pat, 8'h00, FIS_TYPE_SELFTEST});
    chk(got[1], st_data[31:0]);
    chk(got[2], st_data[63:32]);
    chk(got[3], {8'h00, pat, 8'h00, FIS_TYPE_SELFTEST});
    chk(kind, kind_selftest);
  endtask

  task automatic t_abort();
    clr(2'h0);
    stall <= 1'b1;
    hit(0);
    wait_valid();
    hit(4);
    #1 chk({o_idle, o_link_dword_valid}, 32'h2);
    hit(0);
    wait_valid();
    hit(5);
    #1 chk({o_idle, o_link_dword_valid}, 32'h2);
    chk(n_end, 32'd0);
    clr(2'h0);
    stall <= 1'b0;
    mute <= 1'b1;
    hit(3);
    wait_end();
    hit(4);
    #1 chk(o_idle, 32'h1);
    repeat (5) @(posedge i_ref_clk);
    chk(n_done, 32'd0);
    mute <= 1'b0;
  endtask

  initial
  begin
    repeat (4) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_cmd();
    t_ctl();
    t_srst();
    t_dma();
    t_dma_srst();
    t_st();
    t_abort();
    tally_and_finish();
  end
endmodule

`default_nettype wire
